/* File: logic/ppsm_params.svh */
// Register offsets, field layouts, codes and reset values of the pin matrix.
`ifndef PPSM_PARAMS_SVH
`define PPSM_PARAMS_SVH

`define PPSM_NUM_IN       18
`define PPSM_NUM_PA       6
`define PPSM_NUM_PIN      14
`define PPSM_NUM_SRC      28
`define PPSM_IN_W         6
`define PPSM_OUT_W        5

`define PPSM_IN_BASE      6'h00
`define PPSM_OUT_BASE     6'h20
`define PPSM_LOCK_WORD    6'h30

`define PPSM_KEY_FIRST    8'h55
`define PPSM_KEY_SECOND   8'hAA
`define PPSM_OUT_RESET    5'h00
`define PPSM_CODE_CMP2    5'h14
`define PPSM_CODE_LAST    5'h1B
`define PPSM_PORT_C_PINS_FLAG   6'h10

// Power-on input defaults, in input index order.
`define PPSM_DEF_INT      6'h02
`define PPSM_DEF_T0CKI    6'h02
`define PPSM_DEF_T1CKI    6'h05
`define PPSM_DEF_T1G      6'h04
`define PPSM_DEF_T2IN     6'h05
`define PPSM_DEF_CAPTURE_COMPARE_UNIT_1     6'h15
`define PPSM_DEF_CAPTURE_COMPARE_UNIT_2     6'h13
`define PPSM_DEF_CWG      6'h02
`define PPSM_DEF_CLCIN0   6'h13
`define PPSM_DEF_CLCIN1   6'h14
`define PPSM_DEF_CLCIN2   6'h11
`define PPSM_DEF_CLCIN3   6'h05
`define PPSM_DEF_ADACT    6'h12
`define PPSM_DEF_SCLK     6'h10
`define PPSM_DEF_SDAT     6'h11
`define PPSM_DEF_SSEL     6'h13
`define PPSM_DEF_RXDT     6'h15
`define PPSM_DEF_TXCK     6'h14

`endif

/* File: logic/ppsm_pkg.sv */
// Types shared by the pin matrix design.
package ppsm_pkg;
    typedef enum logic [1:0]
    {
        PPSM_IDLE  = 2'h0,
        PPSM_GOT55 = 2'h1,
        PPSM_ARMED = 2'h3
    } ppsm_key_t;
endpackage

/* File: logic/ppsm_top.sv */
// Peripheral pin select matrix with Avalon-MM register access.
//
// Function
// - Output codes 0x01-0x0E route logic cells, waveform, capture, PWM.
// - Codes 0x0F,0x10,0x13,0x15,0x16,0x19,0x1A,0x1B route listed sources.
// - Large package routes to ports A and C plus comparator 2.
// - Each peripheral input has its own pin selection register.
// - Input select field is bits 5:0; bits 7:6 read zero.
// - Input selects take per-input defaults at power-on, else kept.
// - Output select field bits 4:0, zero at power-on, else kept.
// - Power-on restores all selections and removes permanent lock.
// - Lock blocks select writes; changing it needs 0x55 then 0xAA.
// - With one-shot config, lock clears and sets once per reset.
// - A routed peripheral overrides the pin direction as needed.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "ppsm_params.svh"

module ppsm_top
#(
    parameter bit LARGE_PACKAGE = 1'b1
)
(
    input  wire logic                      mclk_in,            // 250 MHz
    input  wire logic                      reset_in,           // Other reset
    input  wire logic                      por_in,             // Power-on/BOR
    input  wire logic                      one_shot_lock_config_bit_in, // Cfg
    input  wire logic [7:0]                avs_address_in,     // Byte address
    input  wire logic                      avs_read_in,        // Read request
    input  wire logic                      avs_write_in,       // Write request
    input  wire logic [31:0]               avs_writedata_in,   // Write data
    input  wire logic [3:0]                avs_byteenable_in,  // Byte lanes
    output logic [31:0]                    avs_readdata_out,   // Read data
    output logic                           avs_waitrequest_out, // Stall
    input  wire logic [5:0]                port_a_pins_in,     // Pad levels A
    input  wire logic [7:0]                port_c_pins_in,     // Pad levels C
    input  wire logic [`PPSM_NUM_PIN-1:0]  port_latch_in,      // Port data
    input  wire logic [`PPSM_NUM_PIN-1:0]  pin_direction_control_in, // 1=in
    input  wire logic [`PPSM_NUM_SRC-1:0]  periph_src_in,      // By code
    input  wire logic [`PPSM_NUM_SRC-1:0]  periph_drive_in,    // Wants drive
    output logic [`PPSM_NUM_PIN-1:0]       pin_out,            // Pad data
    output logic [`PPSM_NUM_PIN-1:0]       pin_oe_n_out,       // Low drives
    output logic [`PPSM_NUM_IN-1:0]        periph_in_out,      // To inputs
    output logic                           selection_lock_bit_out // Locked
);

    logic [`PPSM_IN_W-1:0]  in_sel [`PPSM_NUM_IN];
    logic [`PPSM_IN_W-1:0]  next_in_sel [`PPSM_NUM_IN];
    logic [`PPSM_OUT_W-1:0] out_sel [`PPSM_NUM_PIN];
    logic [`PPSM_OUT_W-1:0] next_out_sel [`PPSM_NUM_PIN];
    logic                   lock;
    logic                   next_lock;
    logic                   set_used;
    logic                   next_set_used;
    ppsm_pkg::ppsm_key_t    key;
    ppsm_pkg::ppsm_key_t    next_key;
    logic                   wait_q;
    logic                   next_wait;
    logic [31:0]            rdata;
    logic [31:0]            next_rdata;
    logic [13:0]            pad_meta;
    logic [13:0]            pad_sync;
    logic [`PPSM_NUM_PIN-1:0] next_pin;
    logic [`PPSM_NUM_PIN-1:0] next_oe_n;
    logic [`PPSM_NUM_IN-1:0]  next_periph;

    // Pin index of a pin present in this package variant.
    function automatic logic pin_present(input int p);
        return (p < `PPSM_NUM_PA) || LARGE_PACKAGE;
    endfunction

    // Output code that names a source this package variant provides.
    function automatic logic code_valid(input logic [`PPSM_OUT_W-1:0] c);
        logic ok;
        ok = (c != 5'h00) && (c <= `PPSM_CODE_LAST);
        ok = ok && (c != 5'h11) && (c != 5'h12);
        ok = ok && (c != 5'h17) && (c != 5'h18);
        if (c == `PPSM_CODE_CMP2)
        begin
            ok = LARGE_PACKAGE;
        end
        return ok;
    endfunction

    // Power-on default of input select i.
    function automatic logic [`PPSM_IN_W-1:0] in_default(input int i);
        logic [`PPSM_IN_W-1:0] d [`PPSM_NUM_IN];
        d = '{`PPSM_DEF_INT, `PPSM_DEF_T0CKI, `PPSM_DEF_T1CKI, `PPSM_DEF_T1G,
              `PPSM_DEF_T2IN, `PPSM_DEF_CAPTURE_COMPARE_UNIT_1, `PPSM_DEF_CAPTURE_COMPARE_UNIT_2, `PPSM_DEF_CWG,
              `PPSM_DEF_CLCIN0, `PPSM_DEF_CLCIN1, `PPSM_DEF_CLCIN2,
              `PPSM_DEF_CLCIN3, `PPSM_DEF_ADACT, `PPSM_DEF_SCLK,
              `PPSM_DEF_SDAT, `PPSM_DEF_SSEL, `PPSM_DEF_RXDT,
              `PPSM_DEF_TXCK};
        return d[i];
    endfunction

    //------------------------------------------------------------------
    // Register bus and selection registers
    //------------------------------------------------------------------

    always_comb
    begin
        logic       req;
        logic       wr;
        logic [5:0] word;
        logic [7:0] wbyte;
        req = avs_read_in || avs_write_in;
        wr = avs_write_in && !wait_q && avs_byteenable_in[0];
        word = avs_address_in[7:2];
        wbyte = avs_writedata_in[7:0];
        next_in_sel = in_sel;
        next_out_sel = out_sel;
        next_lock = lock;
        next_set_used = set_used;
        next_key = key;
        next_wait = !(req && wait_q);
        next_rdata = rdata;
        if (req && wait_q)
        begin
            next_rdata = 32'h0000_0000;
            for (int i = 0; i < `PPSM_NUM_IN; i++)
            begin
                if (word == `PPSM_IN_BASE + 6'(i))
                begin
                    next_rdata[`PPSM_IN_W-1:0] = in_sel[i];
                end
            end
            for (int p = 0; p < `PPSM_NUM_PIN; p++)
            begin
                if (word == `PPSM_OUT_BASE + 6'(p) && pin_present(p))
                begin
                    next_rdata[`PPSM_OUT_W-1:0] = out_sel[p];
                end
            end
            if (word == `PPSM_LOCK_WORD)
            begin
                next_rdata[0] = lock;
            end
        end
        if (wr && !lock)
        begin
            for (int i = 0; i < `PPSM_NUM_IN; i++)
            begin
                if (word == `PPSM_IN_BASE + 6'(i))
                begin
                    next_in_sel[i] = wbyte[`PPSM_IN_W-1:0];
                end
            end
            for (int p = 0; p < `PPSM_NUM_PIN; p++)
            begin
                if (word == `PPSM_OUT_BASE + 6'(p) && pin_present(p))
                begin
                    next_out_sel[p] = wbyte[`PPSM_OUT_W-1:0];
                end
            end
        end
        if (wr)
        begin
            next_key = ppsm_pkg::PPSM_IDLE;
            if (word == `PPSM_LOCK_WORD)
            begin
                unique case (key)
                    ppsm_pkg::PPSM_IDLE:
                    begin
                        if (wbyte == `PPSM_KEY_FIRST)
                        begin
                            next_key = ppsm_pkg::PPSM_GOT55;
                        end
                    end
                    ppsm_pkg::PPSM_GOT55:
                    begin
                        if (wbyte == `PPSM_KEY_SECOND)
                        begin
                            next_key = ppsm_pkg::PPSM_ARMED;
                        end
                    end
                    ppsm_pkg::PPSM_ARMED:
                    begin
                        // Under one-shot config the first set is final.
                        if (!(one_shot_lock_config_bit_in && set_used))
                        begin
                            next_lock = wbyte[0];
                            next_set_used = set_used || wbyte[0];
                        end
                    end
                    default:
                    begin
                        next_key = ppsm_pkg::PPSM_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (por_in)
        begin
            for (int i = 0; i < `PPSM_NUM_IN; i++)
            begin
                in_sel[i] <= in_default(i);
            end
            for (int p = 0; p < `PPSM_NUM_PIN; p++)
            begin
                out_sel[p] <= `PPSM_OUT_RESET;
            end
        end
        else
        begin
            in_sel <= next_in_sel;
            out_sel <= next_out_sel;
        end
        if (por_in || reset_in)
        begin
            lock <= 1'b0;
            set_used <= 1'b0;
            key <= ppsm_pkg::PPSM_IDLE;
            wait_q <= 1'b1;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            lock <= next_lock;
            set_used <= next_set_used;
            key <= next_key;
            wait_q <= next_wait;
            rdata <= next_rdata;
        end
    end

    //------------------------------------------------------------------
    // Pad synchroniser and routing multiplexers
    //------------------------------------------------------------------

    always_comb
    begin
        logic [`PPSM_IN_W-1:0]  s;
        logic [`PPSM_OUT_W-1:0] c;
        s = '0;
        c = '0;
        for (int i = 0; i < `PPSM_NUM_IN; i++)
        begin
            s = in_sel[i];
            if ((s & `PPSM_PORT_C_PINS_FLAG) != 6'h00)
            begin
                next_periph[i] = LARGE_PACKAGE &&
                    pad_sync[`PPSM_NUM_PA + int'(s[2:0])];
            end
            else
            begin
                next_periph[i] = (s[2:0] < 3'h6) && pad_sync[s[2:0]];
            end
        end
        for (int p = 0; p < `PPSM_NUM_PIN; p++)
        begin
            c = out_sel[p];
            next_pin[p] = port_latch_in[p];
            next_oe_n[p] = pin_direction_control_in[p];
            if (code_valid(c))
            begin
                next_pin[p] = periph_src_in[c];
                if (periph_drive_in[c])
                begin
                    next_oe_n[p] = 1'b0;
                end
            end
            if (!pin_present(p))
            begin
                next_pin[p] = 1'b0;
                next_oe_n[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        pad_meta <= {port_c_pins_in, port_a_pins_in};
        pad_sync <= pad_meta;
        if (por_in || reset_in)
        begin
            pin_out <= '0;
            pin_oe_n_out <= '1;
            periph_in_out <= '0;
        end
        else
        begin
            pin_out <= next_pin;
            pin_oe_n_out <= next_oe_n;
            periph_in_out <= next_periph;
        end
    end

    assign avs_readdata_out = rdata;
    assign avs_waitrequest_out = wait_q;
    assign selection_lock_bit_out = lock;

endmodule

/* File: verif/ppsm_monitor.sv */
// Bus timing, field, lock and direction assertions for the pin matrix.
`timescale 1ns/1ps

module ppsm_monitor
(
    input wire logic        mclk_in,                  // Clock
    input wire logic        reset_in,                 // Reset
    input wire logic        por_in,                   // Power-on
    input wire logic [7:0]  avs_address_in,           // Addr
    input wire logic        avs_read_in,              // Read
    input wire logic        avs_write_in,             // Write
    input wire logic [31:0] avs_readdata_out,         // Data
    input wire logic        avs_waitrequest_out,      // Stall
    input wire logic [13:0] pin_direction_control_in, // Dir
    input wire logic [27:0] periph_drive_in,          // Wants
    input wire logic [13:0] pin_oe_n_out,             // Oe
    input wire logic        selection_lock_bit_out    // Lock
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Masks the first edge after reset, where registers still hold reset.
    logic rst_q;
    always_ff @(posedge mclk_in)
        rst_q <= reset_in | por_in;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in || por_in || rst_q);

    sequence s_req;
        $rose(avs_read_in || avs_write_in);
    endsequence
    sequence s_done;
        !avs_waitrequest_out;
    endsequence

    wait_answer_a: assert property (s_req |=> s_done)
        else $error("no answer one cycle after request");
    wait_single_a: assert property (s_done |=> avs_waitrequest_out)
        else $error("wait low longer than one cycle");
    wait_idle_a: assert property (!avs_read_in && !avs_write_in
        && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait dropped without request");
    in_field_a: assert property (s_done and avs_read_in
        && avs_address_in < 8'h48 |-> avs_readdata_out[31:6] == 26'h0)
        else $error("input select upper bits set");
    out_field_a: assert property (s_done and avs_read_in
        && avs_address_in inside {[8'h80:8'hB4]}
        |-> avs_readdata_out[31:5] == 27'h0)
        else $error("output select upper bits set");
    lock_cause_a: assert property (!$stable(selection_lock_bit_out)
        |-> $past(avs_write_in && !avs_waitrequest_out
        && avs_address_in == 8'hC0))
        else $error("lock changed without lock write");
    por_clear_a: assert property (disable iff (1'b0) por_in
        |=> !selection_lock_bit_out && avs_waitrequest_out && &pin_oe_n_out)
        else $error("power-on state wrong");
    dir_keep_a: assert property ($past(periph_drive_in) == 28'h0
        |-> pin_oe_n_out == $past(pin_direction_control_in))
        else $error("direction not from port control");
endmodule

bind ppsm_top ppsm_monitor u_mon (.mclk_in, .reset_in, .por_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
    .avs_waitrequest_out, .pin_direction_control_in, .periph_drive_in,
    .pin_oe_n_out, .selection_lock_bit_out);

/* File: verif/ppsm_periph_model.sv */
// Peripheral outputs and pad levels facing the pin matrix.
`timescale 1ns/1ps

module ppsm_periph_model
(
    input  wire logic        flip_in,    // Invert src and pads
    input  wire logic        drv_en_in,  // Drive req
    output logic [27:0]      src_out,    // By code
    output logic [27:0]      drive_out,  // Wants pin
    output logic [5:0]       pa_out,     // Pads A
    output logic [7:0]       pc_out      // Pads C
);
    assign src_out   = 28'hA5C3E96 ^ {28{flip_in}};
    assign drive_out = drv_en_in ? 28'h0280000 : 28'h0000000;
    assign pa_out    = 6'h2D ^ {6{flip_in}};
    assign pc_out    = 8'hB4 ^ {8{flip_in}};
endmodule

/* File: verif/tb_top.sv */
// Self-checking testbench of the pin matrix.
`timescale 1ns/1ps
`include "ppsm_params.svh"

module tb_top;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        por_in = 1'b1;
    logic        one_shot = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [13:0] latch = 14'h2A5C;
    logic [13:0] dir = 14'h3FFF;
    logic        flip = 1'b0;
    logic        drv_en = 1'b0;
    logic [31:0] rdata, q;
    logic        waitreq, lock;
    logic [27:0] src, drive;
    logic [5:0]  pa;
    logic [7:0]  pc;
    logic [13:0] pin, oe_n;
    logic [17:0] pin_in;
    int          n_fail = 0;
    int          checked = 0;
    int          cycles = 0;

    always #2 mclk_in = ~mclk_in;

    ppsm_periph_model u_far (.flip_in(flip), .drv_en_in(drv_en),
        .src_out(src), .drive_out(drive), .pa_out(pa), .pc_out(pc));

    ppsm_top dut (.mclk_in(mclk_in), .reset_in(reset_in), .por_in(por_in),
        .one_shot_lock_config_bit_in(one_shot), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'h1), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .port_a_pins_in(pa),
        .port_c_pins_in(pc), .port_latch_in(latch),
        .pin_direction_control_in(dir), .periph_src_in(src),
        .periph_drive_in(drive), .pin_out(pin), .pin_oe_n_out(oe_n),
        .periph_in_out(pin_in), .selection_lock_bit_out(lock));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= {24'h0, d};
        wr    <= w;
        rd    <= ~w;
        do
            @(posedge mclk_in);
        while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge mclk_in);
    endtask

    task lock_seq(input logic [7:0] key, input logic v);
        bus(1'b1, 8'hC0, 8'h55);
        bus(1'b1, 8'hC0, key);
        bus(1'b1, 8'hC0, {7'h0, v});
    endtask

    task pulse(input logic por);
        if (por)
            por_in <= 1'b1;
        else
            reset_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        por_in   <= 1'b0;
        reset_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task t_defaults;
        for (int p = 0; p < 14; p++)
        begin
            bus(1'b0, 8'h80 + 8'(4 * p), 8'h00);
            chk(q, 32'h0);
        end
        bus(1'b0, 8'h00, 8'h00);
        chk(q, {26'h0, `PPSM_DEF_INT});
        bus(1'b0, 8'h44, 8'h00);
        chk(q, {26'h0, `PPSM_DEF_TXCK});
        bus(1'b1, 8'hFC, 8'h3F);
        bus(1'b0, 8'hFC, 8'h00);
        chk(q, 32'h0);
    endtask

    task t_out_route;
        int   p;
        logic ok;
        logic e;
        for (int c = 0; c < 28; c++)
        begin
            p = c[0] ? 13 : 0;
            flip <= c[1];
            bus(1'b1, 8'h80 + 8'(4 * p), {3'h7, 5'(c)});
            bus(1'b0, 8'h80 + 8'(4 * p), 8'h00);
            chk(q, {27'h0, 5'(c)});
            ok = c inside {[1:16], [19:22], [25:27]};
            latch[p] <= ~src[c];
            repeat (2) @(posedge mclk_in);
            e = ok ? src[c] : latch[p];
            chk(32'(pin[p]), 32'(e));
        end
    endtask

    task t_in_route;
        logic [5:0] s;
        for (int c = 0; c < 12; c++)
        begin
            s = (c < 6) ? 6'(c) : 6'(c + 10);
            flip <= c[0];
            bus(1'b1, 8'h14, {2'h3, s});
            bus(1'b0, 8'h14, 8'h00);
            chk(q, {26'h0, s});
            repeat (4) @(posedge mclk_in);
            chk(32'(pin_in[5]), 32'(s[4] ? pc[s[2:0]] : pa[s[2:0]]));
        end
        bus(1'b0, 8'h18, 8'h00);
        chk(q, {26'h0, `PPSM_DEF_CAPTURE_COMPARE_UNIT_2});
    endtask

    task t_dir;
        drv_en <= 1'b1;
        bus(1'b1, 8'h88, 8'h13);
        repeat (3) @(posedge mclk_in);
        chk(32'(oe_n[2]), 32'h0);
        drv_en <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk(32'(oe_n[2]), 32'h1);
    endtask

    task t_lock;
        lock_seq(8'hAA, 1'b1);
        chk(32'(lock), 32'h1);
        bus(1'b1, 8'h84, 8'h05);
        bus(1'b0, 8'h84, 8'h00);
        chk(q, 32'h0);
        lock_seq(8'h12, 1'b0);
        chk(32'(lock), 32'h1);
        lock_seq(8'hAA, 1'b0);
        chk(32'(lock), 32'h0);
        bus(1'b1, 8'h84, 8'h05);
        one_shot <= 1'b1;
        pulse(1'b0);
        lock_seq(8'hAA, 1'b1);
        chk(32'(lock), 32'h1);
        lock_seq(8'hAA, 1'b0);
        chk(32'(lock), 32'h1);
        pulse(1'b0);
        chk(32'(lock), 32'h0);
        bus(1'b0, 8'h84, 8'h00);
        chk(q, 32'h5);
        pulse(1'b1);
        bus(1'b0, 8'h84, 8'h00);
        chk(q, 32'h0);
    endtask

    initial
    begin
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        por_in   <= 1'b0;
        @(posedge mclk_in);
        t_defaults;
        t_out_route;
        t_in_route;
        t_dir;
        t_lock;
        print_verdict;
    end

    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            print_verdict;
        end
    end
endmodule
